//--- common/dglp_consts.svh
// Constants of the DDC gain, latency and test pattern configuration bank.
// Assumes byte-wide registers reached at their own offsets.
`ifndef DGLP_CONSTS_SVH
`define DGLP_CONSTS_SVH

// Register offsets
`define DGLP_OFS_GAIN_FIRST 8'h14
`define DGLP_OFS_GAIN_SECOND 8'h16
`define DGLP_OFS_LATENCY 8'h1e
`define DGLP_OFS_GAIN_WIDE 8'h1f
`define DGLP_OFS_PAT_ONE_LO 8'h33
`define DGLP_OFS_PAT_ONE_HI 8'h34
`define DGLP_OFS_PAT_TWO_LO 8'h35
`define DGLP_OFS_PAT_TWO_HI 8'h36
`define DGLP_OFS_PAT_SEL 8'h37

// Field positions
`define DGLP_GAIN_BIT 0
`define DGLP_LAT_MSB 6
`define DGLP_LAT_LSB 4
`define DGLP_SEL_MSB 3
`define DGLP_SEL_LSB 0

// Reset values
`define DGLP_RST_BIT 1'b0
`define DGLP_RST_LAT 3'h0
`define DGLP_RST_WORD 16'h0000
`define DGLP_RST_SEL 4'h0
`define DGLP_RST_BYTE 8'h00

// Fixed output words
`define DGLP_WORD_ZEROS 16'h0000
`define DGLP_WORD_ONES 16'hffff
`define DGLP_WORD_DESKEW 16'haaaa

// Latency register values software writes per complex decimation factor
`define DGLP_LAT_DEC_24_32 8'h10
`define DGLP_LAT_DEC_16_20 8'h20
`define DGLP_LAT_DEC_6_12 8'h40
`define DGLP_LAT_DEC_4_10 8'h50

`endif

//--- common/dglp_pkg.sv
// Types shared by the DDC gain, latency and test pattern configuration bank.
// Assumes 16-bit two's complement I and Q sample words.
package dglp_pkg;

    // One complex output sample of a DDC
    typedef struct packed {
        logic [15:0] i; // In-phase word
        logic [15:0] q; // Quadrature word
    } dglp_iq_s;

    // Test pattern selector codes
    typedef enum logic [3:0] {
        DGLP_TP_NORMAL = 4'h0, // Converter data
        DGLP_TP_ZEROS = 4'h1, // All zeros
        DGLP_TP_ONES = 4'h2, // All ones
        DGLP_TP_SINGLE = 4'h6, // First user pattern
        DGLP_TP_DOUBLE = 4'h7, // Both user patterns in turn
        DGLP_TP_DESKEW = 4'h8 // Fixed deskew word
    } dglp_tp_e;

endpackage

//--- rtl/dglp_gain_sat.sv
// Optional doubling of one two's complement sample with saturation.
// Assumes a purely combinational use; the caller registers the result.
`timescale 1ns/100ps
module dglp_gain_sat #(
    parameter int W = 16 // Sample width
) (
    input wire logic [W-1:0] samp_i, // Sample in
    input wire logic dbl_i, // Apply doubling
    output logic [W-1:0] samp_o // Sample out
);

    logic ovf; // Doubling would leave the word range

    // Top two bits differ: the doubled value does not fit
    assign ovf = samp_i[W-1] ^ samp_i[W-2];

    // Pass, double, or clamp to full scale instead of wrapping
    always_comb begin
        if (!dbl_i) begin
            // No added gain
            samp_o = samp_i;
        end else if (ovf) begin
            // Clamp to the extreme of the input's sign
            if (samp_i[W-1]) begin
                samp_o = {1'b1, {(W-1){1'b0}}};
            end else begin
                samp_o = {1'b0, {(W-1){1'b1}}};
            end
        end else begin
            // Shift left by one is the doubling
            samp_o = {samp_i[W-2:0], 1'b0};
        end
    end

endmodule

//--- rtl/dglp_cfg_top.sv
// Configuration bank for DDC output gain, latency alignment and test
// patterns, with the output stage these settings steer.
// Assumes sample inputs and the path select come from logic on clk_i.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "dglp_consts.svh"
module dglp_cfg_top
    import dglp_pkg::*;
(
    input wire logic clk_i, // 10 MHz clock
    input wire logic rst_n_i, // Synchronous reset, active low
    input wire logic [7:0] reg_addr_i, // Register offset
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
    input wire logic wideband_path_i, // Divide-by-4 or -6 path in use
    input wire logic samp_valid_i, // Sample words valid
    input wire dglp_iq_s ddc0_samp_i, // First DDC sample
    input wire dglp_iq_s ddc1_samp_i, // Second DDC sample
    output logic samp_valid_o, // Output words valid
    output dglp_iq_s ddc0_samp_o, // First DDC output
    output dglp_iq_s ddc1_samp_o, // Second DDC output
    output logic [2:0] latency_alignment_setting_o // To latency alignment
);

    localparam int LANES = 4; // I and Q of two DDCs

    logic first_ddc_double_gain_q; // First DDC doubling
    logic second_ddc_double_gain_q; // Second DDC doubling
    logic wideband_path_double_gain_q; // Wideband path doubling
    logic [2:0] latency_alignment_setting_q; // Latency alignment
    logic [15:0] user_pattern_one_q; // First user pattern
    logic [15:0] user_pattern_two_q; // Second user pattern
    dglp_tp_e pat_sel_q; // Test pattern selector
    logic alt_q; // Second pattern due next sample
    logic [7:0] rdata_q; // Read data register
    logic valid_q; // Output valid register
    logic [15:0] samp_q [LANES]; // Output word registers
    logic [15:0] lane_in [LANES]; // Input words per lane
    logic dbl_first; // Effective doubling, first DDC
    logic dbl_second; // Effective doubling, second DDC

    // Write strobes per register
    logic wr_gain_first;
    logic wr_gain_second;
    logic wr_latency;
    logic wr_gain_wide;
    logic wr_sel;

    assign wr_gain_first = reg_wr_i && (reg_addr_i == `DGLP_OFS_GAIN_FIRST);
    assign wr_gain_second = reg_wr_i && (reg_addr_i == `DGLP_OFS_GAIN_SECOND);
    assign wr_latency = reg_wr_i && (reg_addr_i == `DGLP_OFS_LATENCY);
    assign wr_gain_wide = reg_wr_i && (reg_addr_i == `DGLP_OFS_GAIN_WIDE);
    assign wr_sel = reg_wr_i && (reg_addr_i == `DGLP_OFS_PAT_SEL);

    // Gain bits; reserved bits of the byte are not stored
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            first_ddc_double_gain_q <= `DGLP_RST_BIT;
            second_ddc_double_gain_q <= `DGLP_RST_BIT;
            wideband_path_double_gain_q <= `DGLP_RST_BIT;
        end else begin
            if (wr_gain_first) begin
                first_ddc_double_gain_q <= reg_wdata_i[`DGLP_GAIN_BIT];
            end
            if (wr_gain_second) begin
                second_ddc_double_gain_q <= reg_wdata_i[`DGLP_GAIN_BIT];
            end
            if (wr_gain_wide) begin
                wideband_path_double_gain_q <=
                    reg_wdata_i[`DGLP_GAIN_BIT];
            end
        end
    end

    // Latency alignment field, bits 6 to 4
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            latency_alignment_setting_q <= `DGLP_RST_LAT;
        end else if (wr_latency) begin
            latency_alignment_setting_q <=
                reg_wdata_i[`DGLP_LAT_MSB:`DGLP_LAT_LSB];
        end
    end

    assign latency_alignment_setting_o = latency_alignment_setting_q;

    // User patterns, assembled from low and high byte registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            user_pattern_one_q <= `DGLP_RST_WORD;
            user_pattern_two_q <= `DGLP_RST_WORD;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DGLP_OFS_PAT_ONE_LO: begin
                    user_pattern_one_q[7:0] <= reg_wdata_i;
                end
                `DGLP_OFS_PAT_ONE_HI: begin
                    user_pattern_one_q[15:8] <= reg_wdata_i;
                end
                `DGLP_OFS_PAT_TWO_LO: begin
                    user_pattern_two_q[7:0] <= reg_wdata_i;
                end
                `DGLP_OFS_PAT_TWO_HI: begin
                    user_pattern_two_q[15:8] <= reg_wdata_i;
                end
                default: begin
                    // Other offsets leave the patterns alone
                end
            endcase
        end
    end

    // Selector, low nibble only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pat_sel_q <= dglp_tp_e'(`DGLP_RST_SEL);
        end else if (wr_sel) begin
            pat_sel_q <=
                dglp_tp_e'(reg_wdata_i[`DGLP_SEL_MSB:`DGLP_SEL_LSB]);
        end
    end

    // Read data: valid only in the cycle after the strobe, else zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= `DGLP_RST_BYTE;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DGLP_OFS_GAIN_FIRST: begin
                    rdata_q <= {7'h00, first_ddc_double_gain_q};
                end
                `DGLP_OFS_GAIN_SECOND: begin
                    rdata_q <= {7'h00, second_ddc_double_gain_q};
                end
                `DGLP_OFS_LATENCY: begin
                    rdata_q <= {1'b0, latency_alignment_setting_q, 4'h0};
                end
                `DGLP_OFS_GAIN_WIDE: begin
                    rdata_q <= {7'h00, wideband_path_double_gain_q};
                end
                `DGLP_OFS_PAT_ONE_LO: begin
                    rdata_q <= user_pattern_one_q[7:0];
                end
                `DGLP_OFS_PAT_ONE_HI: begin
                    rdata_q <= user_pattern_one_q[15:8];
                end
                `DGLP_OFS_PAT_TWO_LO: begin
                    rdata_q <= user_pattern_two_q[7:0];
                end
                `DGLP_OFS_PAT_TWO_HI: begin
                    rdata_q <= user_pattern_two_q[15:8];
                end
                `DGLP_OFS_PAT_SEL: begin
                    rdata_q <= {4'h0, pat_sel_q};
                end
                default: begin
                    // Unmapped offset reads zero
                    rdata_q <= `DGLP_RST_BYTE;
                end
            endcase
        end else begin
            rdata_q <= `DGLP_RST_BYTE;
        end
    end

    assign reg_rdata_o = rdata_q;

    // Wideband path takes its own gain; per-DDC bits do not reach it
    assign dbl_first = wideband_path_i ? wideband_path_double_gain_q
                                       : first_ddc_double_gain_q;
    assign dbl_second = wideband_path_i ? wideband_path_double_gain_q
                                        : second_ddc_double_gain_q;

    // Lane order: first I, first Q, second I, second Q
    assign lane_in[0] = ddc0_samp_i.i;
    assign lane_in[1] = ddc0_samp_i.q;
    assign lane_in[2] = ddc1_samp_i.i;
    assign lane_in[3] = ddc1_samp_i.q;

    // Alternation between the two user patterns, per taken sample
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alt_q <= 1'b0;
        end else if (pat_sel_q != DGLP_TP_DOUBLE) begin
            // Restart on the first pattern when the mode is entered
            alt_q <= 1'b0;
        end else if (samp_valid_i) begin
            alt_q <= ~alt_q;
        end
    end

    // Output valid follows input valid by one cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= samp_valid_i;
        end
    end

    assign samp_valid_o = valid_q;

    // Per-lane gain and pattern selection
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [15:0] gained; // Lane word after gain
        logic [15:0] word_d; // Lane word to register

        dglp_gain_sat #(
            .W(16)
        ) u_gain (
            .samp_i(lane_in[g]),
            .dbl_i((g < 2) ? dbl_first : dbl_second),
            .samp_o(gained)
        );

        // Pattern mux; unlisted codes fall back to converter data
        always_comb begin
            case (pat_sel_q)
                DGLP_TP_ZEROS: word_d = `DGLP_WORD_ZEROS;
                DGLP_TP_ONES: word_d = `DGLP_WORD_ONES;
                DGLP_TP_SINGLE: word_d = user_pattern_one_q;
                DGLP_TP_DOUBLE: begin
                    word_d = alt_q ? user_pattern_two_q
                                   : user_pattern_one_q;
                end
                DGLP_TP_DESKEW: word_d = `DGLP_WORD_DESKEW;
                default: word_d = gained;
            endcase
        end

        // Output word register, loaded on each valid sample
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                samp_q[g] <= `DGLP_RST_WORD;
            end else if (samp_valid_i) begin
                samp_q[g] <= word_d;
            end
        end
    end

    assign ddc0_samp_o = {samp_q[0], samp_q[1]};
    assign ddc1_samp_o = {samp_q[2], samp_q[3]};

    // Checks on the configuration and output stage
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_data_normal;
        samp_valid_i && (pat_sel_q == DGLP_TP_NORMAL);
    endsequence

    property p_first_gain;
        s_data_normal and (!wideband_path_i && first_ddc_double_gain_q &&
            (ddc0_samp_i.i[15] == ddc0_samp_i.i[14]))
        |=> ddc0_samp_o.i == {$past(ddc0_samp_i.i[14:0]), 1'b0};
    endproperty
    a_first_gain: assert property (p_first_gain)
        else $error("First DDC output not doubled");

    property p_wide_ignores_ddc;
        s_data_normal and (wideband_path_i && !wideband_path_double_gain_q)
        |=> (ddc0_samp_o == $past(ddc0_samp_i)) &&
            (ddc1_samp_o == $past(ddc1_samp_i));
    endproperty
    a_wide_ignores_ddc: assert property (p_wide_ignores_ddc)
        else $error("Per-DDC gain reached the wideband path");

    property p_second_gain;
        s_data_normal and (!wideband_path_i && second_ddc_double_gain_q &&
            (ddc1_samp_i.q[15] == ddc1_samp_i.q[14]))
        |=> ddc1_samp_o.q == {$past(ddc1_samp_i.q[14:0]), 1'b0};
    endproperty
    a_second_gain: assert property (p_second_gain)
        else $error("Second DDC output not doubled");

    property p_wide_gain;
        s_data_normal and (wideband_path_i && wideband_path_double_gain_q &&
            (ddc1_samp_i.q[15] == ddc1_samp_i.q[14]))
        |=> ddc1_samp_o.q == {$past(ddc1_samp_i.q[14:0]), 1'b0};
    endproperty
    a_wide_gain: assert property (p_wide_gain)
        else $error("Wideband path output not doubled");

    property p_latency_field;
        wr_latency |=> latency_alignment_setting_o ==
            $past(reg_wdata_i[`DGLP_LAT_MSB:`DGLP_LAT_LSB]);
    endproperty
    a_latency_field: assert property (p_latency_field)
        else $error("Latency field does not follow the write");

    sequence s_sel_write_read;
        wr_sel ##1 (reg_rd_i && (reg_addr_i == `DGLP_OFS_PAT_SEL));
    endsequence

    property p_sel_readback;
        s_sel_write_read |=> reg_rdata_o == {4'h0, $past(reg_wdata_i[3:0], 2)};
    endproperty
    a_sel_readback: assert property (p_sel_readback)
        else $error("Selector readback wrong");

    property p_reset_zero;
        disable iff (1'b0)
        !rst_n_i |=> !first_ddc_double_gain_q && !second_ddc_double_gain_q &&
            !wideband_path_double_gain_q && (pat_sel_q == DGLP_TP_NORMAL) &&
            (latency_alignment_setting_o == 3'h0) &&
            (user_pattern_one_q == 16'h0000) &&
            (user_pattern_two_q == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Field not zero after reset");

    property p_fixed_codes;
        samp_valid_i && (pat_sel_q == DGLP_TP_ONES) |=>
            (ddc0_samp_o == 32'hffffffff) && (ddc1_samp_o == 32'hffffffff);
    endproperty
    a_fixed_codes: assert property (p_fixed_codes)
        else $error("All-ones pattern wrong");

    sequence s_two_double;
        (samp_valid_i && !reg_wr_i && (pat_sel_q == DGLP_TP_DOUBLE) && !alt_q)
        ##1 (samp_valid_i && !reg_wr_i && (pat_sel_q == DGLP_TP_DOUBLE));
    endsequence

    property p_alternate;
        s_two_double |-> (ddc0_samp_o.i == user_pattern_one_q)
            ##1 (ddc1_samp_o.q == user_pattern_two_q);
    endproperty
    a_alternate: assert property (p_alternate)
        else $error("User patterns do not alternate");

    property p_deskew;
        samp_valid_i && (pat_sel_q == DGLP_TP_DESKEW) |=>
            (ddc0_samp_o.q == 16'haaaa) && (ddc1_samp_o.i == 16'haaaa);
    endproperty
    a_deskew: assert property (p_deskew)
        else $error("Deskew word wrong");

    property p_saturate;
        s_data_normal and (!wideband_path_i && second_ddc_double_gain_q &&
            !ddc1_samp_i.q[15] && ddc1_samp_i.q[14])
        |=> ddc1_samp_o.q == 16'h7fff;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("Doubled value wrapped");

endmodule

//--- tb/dglp_cfg_top_tb.sv
// Self-checking bench of the DDC gain, latency and test pattern bank.
// Assumes one 10 MHz clock and a synchronous reset, active low.
`timescale 1ns/100ps
`include "dglp_consts.svh"
module dglp_cfg_top_tb
    import dglp_pkg::*;
;
    // Register row: offset, write data, expected readback
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } dglp_tb_reg_s;
    // Gain row: three gain bits, path select, test word
    typedef struct packed {
        logic g0;
        logic g1;
        logic gw;
        logic wb;
        logic [15:0] x;
    } dglp_tb_gain_s;
    // Pattern row: selector code, pattern flag, expected word
    typedef struct packed {
        logic [3:0] code;
        logic pat;
        logic [15:0] w;
    } dglp_tb_pat_s;

    logic clk_i; // Bench clock
    logic rst_n_i = 1'b0; // Reset, active low
    logic [7:0] reg_addr_i = 8'h00; // Register offset
    logic [7:0] reg_wdata_i = 8'h00; // Write data
    logic reg_wr_i = 1'b0; // Write strobe
    logic reg_rd_i = 1'b0; // Read strobe
    logic [7:0] reg_rdata_o; // Read data
    logic wideband_path_i = 1'b0; // Wideband path in use
    logic samp_valid_i = 1'b0; // Input samples valid
    dglp_iq_s ddc0_samp_i = '0; // First DDC sample in
    dglp_iq_s ddc1_samp_i = '0; // Second DDC sample in
    logic samp_valid_o; // Output samples valid
    dglp_iq_s ddc0_samp_o; // First DDC sample out
    dglp_iq_s ddc1_samp_o; // Second DDC sample out
    logic [2:0] latency_alignment_setting_o; // Latency field out
    int miscompares = 0; // Mismatch count
    int tests_run = 0; // Comparison count

    // All mapped offsets, for reset readback
    logic [7:0] ofs [9] = '{`DGLP_OFS_GAIN_FIRST, `DGLP_OFS_GAIN_SECOND,
        `DGLP_OFS_LATENCY, `DGLP_OFS_GAIN_WIDE, `DGLP_OFS_PAT_ONE_LO,
        `DGLP_OFS_PAT_ONE_HI, `DGLP_OFS_PAT_TWO_LO, `DGLP_OFS_PAT_TWO_HI,
        `DGLP_OFS_PAT_SEL};
    // Writes and readbacks; reserved bits written as zero, except 8'h5a written to unmapped offset 8'h15
    dglp_tb_reg_s reg_rows [16] = '{'{8'h14, 8'h01, 8'h01},
        '{8'h16, 8'h01, 8'h01}, '{8'h1f, 8'h01, 8'h01},
        '{8'h1e, 8'h10, 8'h10}, '{8'h1e, 8'h20, 8'h20},
        '{8'h1e, 8'h40, 8'h40}, '{8'h1e, 8'h50, 8'h50},
        '{8'h33, 8'h5a, 8'h5a}, '{8'h34, 8'hc3, 8'hc3},
        '{8'h35, 8'h96, 8'h96}, '{8'h36, 8'h69, 8'h69},
        '{8'h37, 8'h08, 8'h08}, '{8'h37, 8'h0f, 8'h0f},
        '{8'h15, 8'h5a, 8'h00}, '{8'h14, 8'h00, 8'h00},
        '{8'h16, 8'h00, 8'h00}};
    // Gain settings against path select, with clamp boundaries
    dglp_tb_gain_s gain_rows [8] = '{'{1'b1, 1'b1, 1'b0, 1'b0, 16'hc000},
        '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0100},
        '{1'b0, 1'b1, 1'b0, 1'b0, 16'h4000},
        '{1'b1, 1'b1, 1'b0, 1'b1, 16'h0100},
        '{1'b0, 1'b0, 1'b1, 1'b1, 16'hbfff},
        '{1'b0, 1'b0, 1'b1, 1'b1, 16'h0100},
        '{1'b0, 1'b0, 1'b1, 1'b0, 16'h0100},
        '{1'b0, 1'b0, 1'b0, 1'b0, 16'h0100}};
    // Selector codes; unlisted code 3 gives sample data
    dglp_tb_pat_s pat_rows [6] = '{'{DGLP_TP_ZEROS, 1'b1, `DGLP_WORD_ZEROS},
        '{DGLP_TP_ONES, 1'b1, `DGLP_WORD_ONES},
        '{DGLP_TP_SINGLE, 1'b1, 16'hc35a},
        '{DGLP_TP_DESKEW, 1'b1, `DGLP_WORD_DESKEW},
        '{DGLP_TP_NORMAL, 1'b0, 16'h0000}, '{4'h3, 1'b0, 16'h0000}};

    // Device under test
    dglp_cfg_top u_dglp_cfg_top (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .wideband_path_i(wideband_path_i),
        .samp_valid_i(samp_valid_i),
        .ddc0_samp_i(ddc0_samp_i),
        .ddc1_samp_i(ddc1_samp_i),
        .samp_valid_o(samp_valid_o),
        .ddc0_samp_o(ddc0_samp_o),
        .ddc1_samp_o(ddc1_samp_o),
        .latency_alignment_setting_o(latency_alignment_setting_o)
    );

    // Clock of 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Compare and count; four-state so unknowns never match
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // One-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check("reg_rdata_o", {24'h0, e}, {24'h0, reg_rdata_o});
    endtask

    // One valid sample on both DDCs; outputs settled on return
    task automatic smp(input dglp_iq_s a, input dglp_iq_s b);
        @(posedge clk_i);
        samp_valid_i <= 1'b1;
        ddc0_samp_i <= a;
        ddc1_samp_i <= b;
        @(posedge clk_i);
        samp_valid_i <= 1'b0;
        #1;
    endtask

    // Doubling with clamp to the signed 16-bit range
    function automatic logic [15:0] dbl(input logic [15:0] x,
            input logic en);
        logic signed [16:0] t;
        t = $signed({x[15], x});
        t = t + t;
        if (!en) begin
            return x;
        end
        if (t > 17'sd32767) begin
            return 16'h7fff;
        end
        if (t < -17'sd32768) begin
            return 16'h8000;
        end
        return t[15:0];
    endfunction

    // Verdict and end of run
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #(100 * 5000);
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        dglp_iq_s s0;
        dglp_iq_s s1;
        logic en0;
        logic en1;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("samp_valid_o", 32'h0, {31'h0, samp_valid_o});
        check("ddc0_samp_o", 32'h0, ddc0_samp_o);
        foreach (ofs[n]) rd(ofs[n], 8'h00);
        $display("test reset_values done");
        // Table of register writes and readbacks
        for (int n = 0; n < 16; n++) begin
            wr(reg_rows[n].a, reg_rows[n].d);
            rd(reg_rows[n].a, reg_rows[n].e);
            if (reg_rows[n].a == `DGLP_OFS_LATENCY) begin
                check("latency", {29'h0, reg_rows[n].e[6:4]},
                    {29'h0, latency_alignment_setting_o});
            end
        end
        $display("test register_table done");
        // Selector back to normal data so the gain checks apply
        wr(`DGLP_OFS_PAT_SEL, 8'h00);
        // Table of gain settings
        for (int n = 0; n < 8; n++) begin
            wr(`DGLP_OFS_GAIN_FIRST, {7'h0, gain_rows[n].g0});
            wr(`DGLP_OFS_GAIN_SECOND, {7'h0, gain_rows[n].g1});
            wr(`DGLP_OFS_GAIN_WIDE, {7'h0, gain_rows[n].gw});
            wideband_path_i <= gain_rows[n].wb;
            en0 = gain_rows[n].wb ? gain_rows[n].gw : gain_rows[n].g0;
            en1 = gain_rows[n].wb ? gain_rows[n].gw : gain_rows[n].g1;
            s0 = {gain_rows[n].x, ~gain_rows[n].x};
            s1 = {16'h8001, gain_rows[n].x};
            smp(s0, s1);
            check("ddc0 gain", {dbl(s0.i, en0), dbl(s0.q, en0)},
                ddc0_samp_o);
            check("ddc1 gain", {dbl(s1.i, en1), dbl(s1.q, en1)},
                ddc1_samp_o);
            check("samp_valid_o", 32'h1, {31'h0, samp_valid_o});
        end
        $display("test gain_table done");
        // Table of selector codes, gains now off
        s0 = {16'h0100, 16'hff00};
        s1 = {16'h7fff, 16'h8000};
        for (int n = 0; n < 6; n++) begin
            wr(`DGLP_OFS_PAT_SEL, {4'h0, pat_rows[n].code});
            smp(s0, s1);
            check("ddc0 pattern", pat_rows[n].pat ?
                {pat_rows[n].w, pat_rows[n].w} : s0, ddc0_samp_o);
            check("ddc1 pattern", pat_rows[n].pat ?
                {pat_rows[n].w, pat_rows[n].w} : s1, ddc1_samp_o);
        end
        $display("test pattern_table done");
        // Alternating patterns over three back-to-back samples
        wr(`DGLP_OFS_PAT_SEL, {4'h0, DGLP_TP_DOUBLE});
        @(posedge clk_i);
        samp_valid_i <= 1'b1;
        @(posedge clk_i);
        #1;
        check("double 1", 32'hc35ac35a, ddc1_samp_o);
        @(posedge clk_i);
        #1;
        check("double 2", 32'h69966996, ddc0_samp_o);
        @(posedge clk_i);
        samp_valid_i <= 1'b0;
        #1;
        check("double 3", 32'hc35ac35a, ddc0_samp_o);
        $display("test double_pattern done");
        // Write then read with no gap; data stands one cycle only
        @(posedge clk_i);
        reg_addr_i <= `DGLP_OFS_PAT_SEL;
        reg_wdata_i <= 8'h01;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check("back to back", 32'h01, {24'h0, reg_rdata_o});
        @(posedge clk_i);
        #1;
        check("read released", 32'h00, {24'h0, reg_rdata_o});
        $display("test back_to_back done");
        // Reset in mid-run clears every field, the latency output and the second DDC output
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("latency", 32'h0, {29'h0, latency_alignment_setting_o});
        check("ddc1_samp_o", 32'h0, ddc1_samp_o);
        foreach (ofs[n]) rd(ofs[n], 8'h00);
        $display("test mid_run_reset done");
        report_and_stop();
    end
endmodule
